// file: sbs_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
// far side: late write data, and a busy bus whenever no data is due
module sbs_ctrl_model (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        cke_n,
  input  wire logic        flow,
  input  wire logic        wr_cmd,
  input  wire logic [35:0] wr_data,
  output logic      [35:0] dq_in
);
  logic        v1_ff, v2_ff;
  logic [35:0] d1_ff, d2_ff, junk_ff;
  //////////////////////////////////////////////////////////////////////
  // data trails its command by enabled edges only, so stalls stretch it
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      {v1_ff, v2_ff, d1_ff, d2_ff} <= '0;
    end else if (!cke_n) begin
      {v1_ff, d1_ff} <= {wr_cmd, wr_data};
      {v2_ff, d2_ff} <= {v1_ff, d1_ff};
    end
  end
  // idle bus toggles so a sample taken on the wrong edge never matches
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) junk_ff <= 36'h0;
    else junk_ff <= ~dq_in;
  end
  // one enabled edge late in flow, two when pipelined
  assign dq_in = flow ? (v1_ff ? d1_ff : junk_ff)
                      : (v2_ff ? d2_ff : junk_ff);
endmodule // sbs_ctrl_model
`default_nettype wire

// file: sbs_pkg.sv
`default_nettype none
package sbs_pkg;

  ////////////////////////////////////////////////////////////////////////
  // data bus shape
  localparam int LANE_W = 9;      // one byte lane, parity bit included
  localparam int LANES  = 4;      // byte lanes on the data bus
  localparam int BURST_W = 2;     // burst counter width

  ////////////////////////////////////////////////////////////////////////
  // clock period in ps; sleep timing in cycles of CLK_SYS
  localparam int CLK_PERIOD_PS = 5000;
  localparam logic [1:0] SLEEP_ENTRY_CYC    = 2'h2;
  localparam logic [1:0] SLEEP_RECOVERY_CYC = 2'h2;

  ////////////////////////////////////////////////////////////////////////
  // asynchronous pin synchroniser: bit positions and reset values
  localparam int SYNC_W  = 4;
  localparam int PIN_OE  = 0;     // output enable, active low
  localparam int PIN_SLP = 1;     // sleep request
  localparam int PIN_PT  = 2;     // pass-through select, active low
  localparam int PIN_BO  = 3;     // burst order select, active low
  // output disabled, awake, pipelined, linear
  localparam logic [SYNC_W-1:0] PIN_RST = 4'h5;

  ////////////////////////////////////////////////////////////////////////
  // reset values of the datapath
  localparam logic [BURST_W-1:0] CNT_RST = 2'h0;
  localparam logic [1:0]         DUE_RST = 2'h0;

  // command decoded at an enabled edge
  typedef enum logic [2:0] {
    CMD_DESEL,
    CMD_READ,
    CMD_WRITE,
    CMD_ABORT,
    CMD_CONT
  } sbs_cmd_t;

  // kind of burst that a continue cycle extends
  typedef enum logic [1:0] {
    BK_IDLE,
    BK_READ,
    BK_WRITE
  } sbs_burst_t;

endpackage
`default_nettype wire

// file: sbs_sram_if.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// - selected read load latches address, starts read
// - write load writes enabled lanes; none aborts
// - advance continues burst, ignores strobe and selects
// - any select inactive on load deselects, bus off
// - output disabled read is dummy, bus off
// - drivers turned off during write cycles
// - clock enable high holds burst, buffer and read state; output disable and sleep still act
// - outputs high impedance at power-up
// - 2-bit counter advances every burst continue
// - counter returns to start after four
// - linear order increments modulo four
// - interleaved order xors loaded value
// - pass-through low flow, high/open pipelined
// - sleep entered two cycles after request
// - normal operation two cycles after release
// - sleep deselects, ignores inputs, bus off
// - open sleep request means awake
// - pipelined read data one edge later
// - each lane enable gates its 9 bits
module sbs_sram_if #(
  parameter int ADDR_W    = 8,
  parameter int LANES     = sbs_pkg::LANES,
  parameter int BUF_DEPTH = 2
) (
  input  wire logic                          CLK_SYS,
  input  wire logic                          RST_N,
  input  wire logic [ADDR_W-1:0]             ADDR,
  input  wire logic                          CKE_N,
  input  wire logic                          LOAD_OR_ADVANCE,
  input  wire logic                          WRITE_N,
  input  wire logic [LANES-1:0]              BYTE_LANE_ENABLES_N,
  input  wire logic                          SELECT1_N,
  input  wire logic                          SELECT2,
  input  wire logic                          SELECT3_N,
  input  wire logic                          OUTPUT_ENABLE_N,
  input  wire logic                          SLEEP_REQUEST,
  input  wire logic                          BURST_ORDER_SELECT_N,
  input  wire logic                          PASS_THROUGH_SELECT_N,
  input  wire logic [LANES*sbs_pkg::LANE_W-1:0] DQ_IN,
  output var  logic [LANES*sbs_pkg::LANE_W-1:0] DQ_OUT,
  output var  logic                          DQ_OE
);

  localparam int DW     = LANES * sbs_pkg::LANE_W;
  localparam int WORDS  = 1 << ADDR_W;
  localparam int BW     = sbs_pkg::BURST_W;
  localparam int BUF_AW = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
  localparam logic [BUF_AW:0] BUF_FULL = (BUF_AW+1)'(BUF_DEPTH);
  localparam logic [BUF_AW-1:0] BUF_LAST = BUF_AW'(BUF_DEPTH - 1);

  // low address bits of a burst step, linear or interleaved
  function automatic logic [BW-1:0] burst_low(
    input logic [BW-1:0] base,
    input logic [BW-1:0] step,
    input logic          ilv
  );
    burst_low = ilv ? (base ^ step) : BW'(base + step);
  endfunction

  // next slot index of the write buffer, wrapping at its depth
  function automatic logic [BUF_AW-1:0] buf_next(
    input logic [BUF_AW-1:0] idx
  );
    buf_next = (idx == BUF_LAST) ? '0 : BUF_AW'(idx + 1'b1);
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // asynchronous pins: three flops, change taken when 2nd and 3rd agree
  logic [sbs_pkg::SYNC_W-1:0] pin_s0_ff;
  logic [sbs_pkg::SYNC_W-1:0] pin_s1_ff;
  logic [sbs_pkg::SYNC_W-1:0] pin_s2_ff;
  logic [sbs_pkg::SYNC_W-1:0] pin_st_ff;
  logic                       oe_off;
  logic                       slp_req;
  logic                       pipe;
  logic                       ilv;

  // synchroniser chain
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      pin_s0_ff <= sbs_pkg::PIN_RST;
      pin_s1_ff <= sbs_pkg::PIN_RST;
      pin_s2_ff <= sbs_pkg::PIN_RST;
    end else begin
      pin_s0_ff <= {BURST_ORDER_SELECT_N, PASS_THROUGH_SELECT_N,
                    SLEEP_REQUEST, OUTPUT_ENABLE_N};
      pin_s1_ff <= pin_s0_ff;
      pin_s2_ff <= pin_s1_ff;
    end
  end

  // an open pin never agrees, so the default level is kept
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      pin_st_ff <= sbs_pkg::PIN_RST;
    end else begin
      for (int i = 0; i < sbs_pkg::SYNC_W; i++) begin
        if (pin_s1_ff[i] == pin_s2_ff[i]) begin
          pin_st_ff[i] <= pin_s2_ff[i];
        end
      end
    end
  end

  assign oe_off  = pin_st_ff[sbs_pkg::PIN_OE];
  assign slp_req = pin_st_ff[sbs_pkg::PIN_SLP];
  assign pipe    = pin_st_ff[sbs_pkg::PIN_PT];  // high is pipelined
  assign ilv     = pin_st_ff[sbs_pkg::PIN_BO];  // high is interleaved

  //////////////////////////////////////////////////////////////////////////
  // sleep entry and exit; burst state is left untouched while asleep
  logic       sleep_ff;
  logic [1:0] slp_cnt_ff;
  logic [1:0] slp_lim;

  assign slp_lim = slp_req ? sbs_pkg::SLEEP_ENTRY_CYC
                           : sbs_pkg::SLEEP_RECOVERY_CYC;

  // a short glitch on the request resets the count
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      sleep_ff   <= 1'b0;
      slp_cnt_ff <= 2'h0;
    end else if (slp_req != sleep_ff) begin
      if (slp_cnt_ff == 2'(slp_lim - 2'h1)) begin
        sleep_ff   <= slp_req;
        slp_cnt_ff <= 2'h0;
      end else begin
        slp_cnt_ff <= 2'(slp_cnt_ff + 2'h1);
      end
    end else begin
      slp_cnt_ff <= 2'h0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // command decode
  sbs_pkg::sbs_cmd_t   cmd;
  sbs_pkg::sbs_burst_t kind_ff;
  logic                sel;
  logic                no_lanes;
  logic                act;
  logic                rd_go;
  logic                rd_fire;
  logic                wr_go;
  logic                go;

  assign sel      = !SELECT1_N && SELECT2 && !SELECT3_N;
  assign no_lanes = &BYTE_LANE_ENABLES_N;
  // a stalled or sleeping edge changes nothing except the bus-off override of output disable and sleep
  assign act      = !CKE_N && !sleep_ff;

  // load cycles look at selects and strobe, continues do not
  always_comb begin
    cmd = sbs_pkg::CMD_CONT;
    if (!LOAD_OR_ADVANCE) begin
      if (!sel) begin
        cmd = sbs_pkg::CMD_DESEL;
      end else if (WRITE_N) begin
        cmd = sbs_pkg::CMD_READ;
      end else if (no_lanes) begin
        cmd = sbs_pkg::CMD_ABORT;
      end else begin
        cmd = sbs_pkg::CMD_WRITE;
      end
    end
  end

  assign rd_go   = (cmd == sbs_pkg::CMD_READ) ||
                   (cmd == sbs_pkg::CMD_CONT && kind_ff == sbs_pkg::BK_READ);
  assign rd_fire = rd_go && !oe_off;
  assign wr_go   = (cmd == sbs_pkg::CMD_WRITE) ||
                   (cmd == sbs_pkg::CMD_CONT && kind_ff == sbs_pkg::BK_WRITE &&
                    !no_lanes);

  //////////////////////////////////////////////////////////////////////////
  // write buffer: address and lane enables wait here for late data
  logic [ADDR_W-1:0] wb_addr_ff [BUF_DEPTH];
  logic [LANES-1:0]  wb_be_ff   [BUF_DEPTH];
  logic [BUF_AW-1:0] wb_wr_ff;
  logic [BUF_AW-1:0] wb_rd_ff;
  logic [BUF_AW:0]   wb_cnt_ff;
  logic [1:0]        due_ff;
  logic              push_valid;
  logic              push_ready;
  logic              pop_valid;
  logic              pop_ready;
  logic              push;
  logic              pop;
  logic [ADDR_W-1:0] mem_addr;

  // data edge: one enabled edge later flowing, two pipelined
  assign pop_valid  = (wb_cnt_ff != '0);
  assign pop_ready  = act && (pipe ? due_ff[1] : due_ff[0]);
  assign pop        = pop_valid && pop_ready;
  assign push_valid = act && wr_go;
  // a slot freed at the same edge may be refilled
  assign push_ready = (wb_cnt_ff != BUF_FULL) || pop;
  // a write that finds no slot holds the whole command
  assign go         = act && (push_ready || !wr_go);
  assign push       = push_valid && go;

  // slot storage
  always_ff @(posedge CLK_SYS) begin
    if (push) begin
      wb_addr_ff[wb_wr_ff] <= mem_addr;
      wb_be_ff[wb_wr_ff]   <= BYTE_LANE_ENABLES_N;
    end
  end

  // pointers, fill level and the data-due pipeline
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      wb_wr_ff  <= '0;
      wb_rd_ff  <= '0;
      wb_cnt_ff <= '0;
      due_ff    <= sbs_pkg::DUE_RST;
    end else begin
      if (push) begin
        wb_wr_ff <= buf_next(wb_wr_ff);
      end
      if (pop) begin
        wb_rd_ff <= buf_next(wb_rd_ff);
      end
      wb_cnt_ff <= (BUF_AW+1)'(wb_cnt_ff + push - pop);
      if (act) begin
        due_ff <= {due_ff[0], push};
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // burst address counter
  logic [BW-1:0]        base_ff;
  logic [BW-1:0]        cnt_ff;
  logic [BW-1:0]        cnt_nx;
  logic [ADDR_W-BW-1:0] hi_ff;

  assign cnt_nx = BW'(cnt_ff + 1'b1);
  // load cycles use the pins, continues the counter
  assign mem_addr = (cmd == sbs_pkg::CMD_CONT)
                  ? {hi_ff, burst_low(base_ff, cnt_nx, ilv)}
                  : ADDR;

  // burst bookkeeping, held on stalled edges
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      kind_ff <= sbs_pkg::BK_IDLE;
      base_ff <= sbs_pkg::CNT_RST;
      cnt_ff  <= sbs_pkg::CNT_RST;
      hi_ff   <= '0;
    end else if (go) begin
      unique case (cmd)
        sbs_pkg::CMD_READ, sbs_pkg::CMD_WRITE: begin
          kind_ff <= (cmd == sbs_pkg::CMD_READ) ? sbs_pkg::BK_READ
                                                : sbs_pkg::BK_WRITE;
          base_ff <= ADDR[BW-1:0];
          hi_ff   <= ADDR[ADDR_W-1:BW];
          cnt_ff  <= sbs_pkg::CNT_RST;
        end
        sbs_pkg::CMD_ABORT, sbs_pkg::CMD_DESEL: begin
          kind_ff <= sbs_pkg::BK_IDLE;
        end
        sbs_pkg::CMD_CONT: begin
          // deselect-continue has no burst to step
          if (kind_ff != sbs_pkg::BK_IDLE) begin
            cnt_ff <= cnt_nx;
          end
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // storage array; writes only the enabled lanes
  logic [DW-1:0] mem_ff [WORDS];

  // array is not reset: contents are undefined after power-up
  always_ff @(posedge CLK_SYS) begin
    if (pop) begin
      for (int l = 0; l < LANES; l++) begin
        if (!wb_be_ff[wb_rd_ff][l]) begin
          mem_ff[wb_addr_ff[wb_rd_ff]][l*sbs_pkg::LANE_W +: sbs_pkg::LANE_W]
            <= DQ_IN[l*sbs_pkg::LANE_W +: sbs_pkg::LANE_W];
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // read path: core stage, then output register on the pins
  logic          rd_v_ff;
  logic [DW-1:0] rd_data_ff;
  logic [DW-1:0] dq_out_ff;
  logic          dq_oe_ff;

  // read of a slot still in the buffer returns the old word
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      rd_v_ff    <= 1'b0;
      rd_data_ff <= '0;
      dq_out_ff  <= '0;
      dq_oe_ff   <= 1'b0;
    end else begin
      if (act) begin
        rd_v_ff    <= go && rd_fire;
        rd_data_ff <= mem_ff[mem_addr];
        if (pipe) begin
          dq_out_ff <= rd_data_ff;
          dq_oe_ff  <= rd_v_ff;
        end else begin
          dq_out_ff <= mem_ff[mem_addr];
          dq_oe_ff  <= go && rd_fire;
        end
      end
      // output enable and sleep override at any edge, stalled or not
      if (oe_off || sleep_ff) begin
        dq_oe_ff <= 1'b0;
      end
    end
  end

  assign DQ_OUT = dq_out_ff;
  assign DQ_OE  = dq_oe_ff;

  //////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);

  logic [BW-1:0] ld_low;
  logic [DW-1:0] core_word;
  assign ld_low    = ADDR[BW-1:0];
  assign core_word = mem_ff[mem_addr]; // word the core shows this cycle

  sequence pipe_rd_s;
    go && rd_fire && pipe;
  endsequence

  sequence pipe_out_s;
    act && pipe && !oe_off;
  endsequence

  sequence cont_s;
    go && cmd == sbs_pkg::CMD_CONT && kind_ff != sbs_pkg::BK_IDLE;
  endsequence

  read_start_a : assert property (
    go && cmd == sbs_pkg::CMD_READ |=>
      kind_ff == sbs_pkg::BK_READ && base_ff == $past(ld_low) &&
      cnt_ff == 2'h0)
    else $error("read load did not start a read burst");

  abort_nowrite_a : assert property (
    go && cmd == sbs_pkg::CMD_ABORT |=> wb_cnt_ff <= $past(wb_cnt_ff))
    else $error("write abort queued a write");

  desel_off_a : assert property (
    act && cmd == sbs_pkg::CMD_DESEL |=>
      kind_ff == sbs_pkg::BK_IDLE && !rd_v_ff)
    else $error("deselect left a read in flight");

  // a stalled edge may keep earlier read data on the bus, so only a pipelined
  // enabled edge with no read in flight must release it
  idle_off_a : assert property (
    act && pipe && !rd_v_ff |=> !DQ_OE)
    else $error("bus driven with no read in flight");

  dummy_read_a : assert property (
    act && rd_go && oe_off |=> !rd_v_ff && !DQ_OE)
    else $error("read with output disabled drove the bus");

  write_off_a : assert property (
    act && wr_go && !pipe |=> !DQ_OE)
    else $error("bus driven during a write cycle");

  stall_hold_a : assert property (
    !act |=> $stable(cnt_ff) && $stable(kind_ff) && $stable(wb_cnt_ff) &&
      $stable(due_ff))
    else $error("state moved on an ignored edge");

  burst_step_a : assert property (
    cont_s |=> cnt_ff == 2'($past(cnt_ff) + 2'h1))
    else $error("burst counter did not advance");

  burst_wrap_a : assert property (
    cont_s [*4] |=> cnt_ff == $past(cnt_ff, 4))
    else $error("burst did not return to its start");

  burst_order_a : assert property (
    cont_s |-> mem_addr[BW-1:0] ==
      (ilv ? (base_ff ^ cnt_nx) : 2'(base_ff + cnt_ff + 2'h1)))
    else $error("burst address out of order");

  flow_read_a : assert property (
    go && rd_fire && !pipe |=> DQ_OE && DQ_OUT == $past(core_word))
    else $error("flow-through read not on the bus");

  sleep_entry_a : assert property (
    $rose(slp_req) && !sleep_ff ##1 slp_req |=> sleep_ff)
    else $error("sleep not entered two cycles after request");

  sleep_exit_a : assert property (
    $fell(slp_req) && sleep_ff ##1 !slp_req |=> !sleep_ff)
    else $error("sleep not left two cycles after release");

  sleep_quiet_a : assert property (
    sleep_ff |=> !DQ_OE && $stable(kind_ff) && $stable(cnt_ff))
    else $error("activity while asleep");

  pipe_read_a : assert property (
    pipe_rd_s ##1 pipe_out_s |=> DQ_OE && DQ_OUT == $past(rd_data_ff))
    else $error("pipelined read data not one edge later");

endmodule // sbs_sram_if
`default_nettype wire

// file: sync_burst_sram_interface_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin \
  num_checks++; \
  if ((g) !== (e)) begin \
    err_total++; \
    $display("[FAIL] %s expected %h seen %h", nm, e, g); \
  end \
end
module sync_burst_sram_interface_tb_top;
  logic        clk_sys, rst_n, cke_n, la, wr_n, s1_n, s2, s3_n;
  logic        oe_n, slp, bo_n, pt_n, wr_cmd, dq_oe, flow, ilv;
  logic [3:0]  ln_n;
  logic [7:0]  addr, wcnt;
  logic [35:0] wr_data, dq_in, dq_out;
  logic [35:0] em [256];
  int          err_total, num_checks;
  localparam logic [8:1] STALL_PAT = 8'h37;
  localparam logic [8:1] STALL_OE  = 8'h70;

  sbs_sram_if #(.ADDR_W(8)) sbs_sram_if_inst (
    .CLK_SYS(clk_sys), .RST_N(rst_n), .ADDR(addr), .CKE_N(cke_n),
    .LOAD_OR_ADVANCE(la), .WRITE_N(wr_n), .BYTE_LANE_ENABLES_N(ln_n),
    .SELECT1_N(s1_n), .SELECT2(s2), .SELECT3_N(s3_n),
    .OUTPUT_ENABLE_N(oe_n), .SLEEP_REQUEST(slp),
    .BURST_ORDER_SELECT_N(bo_n), .PASS_THROUGH_SELECT_N(pt_n),
    .DQ_IN(dq_in), .DQ_OUT(dq_out), .DQ_OE(dq_oe));

  sbs_ctrl_model sbs_ctrl_model_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .cke_n(cke_n), .flow(flow),
    .wr_cmd(wr_cmd), .wr_data(wr_data), .dq_in(dq_in));

  //////////////////////////////////////////////////////////////////////
  // clock at 200 MHz
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic end_sim;
    if (err_total == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // burst address: linear adds, interleaved xors the loaded low bits
  function automatic logic [7:0] badr(input logic [7:0] a, input int j);
    logic [1:0] s;
    s = j[1:0];
    return {a[7:2], ilv ? a[1:0] ^ s : a[1:0] + s};
  endfunction

  // one command, sampled at the following rising edge; s = active selects
  task automatic step(input logic ck, input logic l, input logic w,
                      input logic [3:0] b, input logic [7:0] a,
                      input logic [2:0] s);
    @(posedge clk_sys);
    cke_n <= ck;
    la <= l;
    wr_n <= w;
    ln_n <= b;
    addr <= a;
    {s3_n, s2, s1_n} <= {~s[2], s[1], ~s[0]};
  endtask

  task automatic idle(input int n);
    repeat (n) step(1'b0, 1'b0, 1'b1, 4'hf, 8'h00, 3'h0);
  endtask

  // continues carry junk address, no selects and a flipped strobe on purpose
  task automatic burst(input logic wr, input logic [7:0] a,
                       input logic [3:0] b, input int n);
    int          lag;
    logic [35:0] d;
    lag = flow ? 1 : 2;
    for (int i = 0; i < n + 2; i++) begin
      if (i < n) begin
        if (i == 0) step(1'b0, 1'b0, !wr, b, a, 3'h7);
        else step(1'b0, 1'b1, wr, b, ~a, 3'h0);
        d = {a, wcnt, ~a, wcnt ^ 8'h3c, 4'h9};
        wcnt++;
        if (wr) begin
          wr_data <= d;
          for (int l = 0; l < 4; l++)
            if (!b[l]) em[badr(a, i)][l*9 +: 9] = d[l*9 +: 9];
        end
      end else idle(1);
      wr_cmd <= wr && (i < n);
      #1;
      if (wr) `CHK("oe_write", 1'b0, dq_oe)
      else if (i >= lag && i - lag < n)
        `CHK("read_beat", {1'b1, em[badr(a, i - lag)]}, {dq_oe, dq_out})
    end
    idle(1);
    #1 `CHK("oe_after", 1'b0, dq_oe)
  endtask

  //////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {rst_n, cke_n, la, wr_n, s1_n, s2, s3_n} = 7'h1a;
    {oe_n, slp, bo_n, pt_n, wr_cmd, flow, ilv} = 7'h08;
    {ln_n, addr, wcnt, wr_data} = '1;
    err_total = 0;
    num_checks = 0;
    repeat (20) @(posedge clk_sys);
    `CHK("oe_reset", 1'b0, dq_oe)
    rst_n <= 1'b1;
    idle(6);
    burst(1'b1, 8'h10, 4'h0, 4);
    burst(1'b1, 8'h21, 4'h0, 5);
    burst(1'b1, 8'h12, 4'ha, 1);
    burst(1'b1, 8'h13, 4'hf, 1);
    burst(1'b0, 8'h11, 4'h0, 5);
    burst(1'b0, 8'h23, 4'h0, 4);
    // each select alone turns a load into a deselect; continue stays dead
    for (int k = 0; k < 3; k++) begin
      step(1'b0, 1'b0, 1'b1, 4'h0, 8'h10, 3'h7 ^ (3'h1 << k));
      step(1'b0, 1'b1, 1'b1, 4'h0, 8'h00, 3'h7);
      repeat (2) begin
        idle(1);
        #1 `CHK("oe_desel", 1'b0, dq_oe)
      end
    end
    // stalled edges neither launch nor drop read data
    step(1'b0, 1'b0, 1'b1, 4'h0, 8'h10, 3'h7);
    for (int k = 1; k <= 8; k++) begin
      step(STALL_PAT[k], 1'b0, 1'b1, 4'hf, 8'h00, 3'h0);
      #1 `CHK("oe_stall", STALL_OE[k], dq_oe)
      if (STALL_OE[k]) `CHK("dq_stall", em[8'h10], dq_out)
    end
    // dummy reads stay off the bus yet still step the counter
    @(posedge clk_sys);
    oe_n <= 1'b1;
    idle(6);
    step(1'b0, 1'b0, 1'b1, 4'h0, 8'h10, 3'h7);
    step(1'b0, 1'b1, 1'b1, 4'h0, 8'h00, 3'h7);
    oe_n <= 1'b0;
    repeat (6) begin
      step(1'b1, 1'b0, 1'b1, 4'hf, 8'h00, 3'h0);
      #1 `CHK("oe_dummy", 1'b0, dq_oe)
    end
    step(1'b0, 1'b1, 1'b1, 4'h0, 8'h00, 3'h7);
    idle(2);
    #1 `CHK("dummy_adv", {1'b1, em[8'h12]}, {dq_oe, dq_out})
    // flow-through timing, then interleaved order
    @(posedge clk_sys);
    pt_n <= 1'b0;
    flow = 1'b1;
    idle(6);
    burst(1'b1, 8'h30, 4'h0, 2);
    burst(1'b0, 8'h30, 4'h0, 2);
    @(posedge clk_sys);
    bo_n <= 1'b1;
    ilv = 1'b1;
    idle(6);
    burst(1'b0, 8'h21, 4'h0, 4);
    burst(1'b1, 8'h31, 4'h0, 4);
    burst(1'b0, 8'h32, 4'h0, 5);
    // sleep only with nothing pending; recovery sees deselects only
    @(posedge clk_sys);
    slp <= 1'b1;
    idle(8);
    step(1'b0, 1'b0, 1'b1, 4'h0, 8'h10, 3'h7);
    repeat (3) begin
      idle(1);
      #1 `CHK("oe_sleep", 1'b0, dq_oe)
    end
    @(posedge clk_sys);
    slp <= 1'b0;
    idle(8);
    burst(1'b0, 8'h10, 4'h0, 1);
    end_sim();
  end

  // a hang counts as a mismatch
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_total++;
    end_sim();
  end
endmodule // sync_burst_sram_interface_tb_top
`default_nettype wire
